// [logic/tcm_top.sv]
`timescale 1ns/1ps
`include "tcm_map.svh"
module tcm_top
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel pins
  output logic output_reference,
  output logic channel_output,
  output logic update_event
);
  import tcm_pkg::*;

  typedef struct packed {
    tcm_bus_state_t wst;
    tcm_bus_state_t rst;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] mode_reg;
    logic counter_en;
    logic one_pulse_mode;
    logic chan_en;
    logic output_polarity;
    logic [15:0] counter_value;
    logic [15:0] reload;
    logic [15:0] cmp_preload;
    logic [15:0] cmp_active;
    logic upd;
    logic chan_out;
  } tcm_top_state_t;

  tcm_top_state_t st;
  tcm_top_state_t next_st;
  tcm_cmp_if cmp_bus ();

  logic wr_fire;
  logic rd_fire;
  logic upd_gen_wr;
  logic overflow;
  logic upd_now;
  logic [15:0] wd16;
  logic pe;

  // --------------------------------------------------------------------------
  // Reference generator
  // --------------------------------------------------------------------------
  assign cmp_bus.mode = st.mode_reg[`TCM_OCM_MSB:`TCM_OCM_LSB];
  assign cmp_bus.output_dir = (st.mode_reg[`TCM_DIR_MSB:`TCM_DIR_LSB] == `TCM_DIR_OUT);
  assign cmp_bus.counter_value = st.counter_value;
  assign cmp_bus.compare_value = st.cmp_active;

  tcm_ref_gen u_ref
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cmp(cmp_bus.gen)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    wr_fire = 1'b0;
    rd_fire = 1'b0;
    upd_gen_wr = 1'b0;
    wd16 = st.wdata[15:0];
    pe = st.mode_reg[`TCM_PE_BIT];

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && !st.aw_got && st.wst == TCM_IDLE)
    begin
      next_st.aw_got = 1'b1;
      next_st.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_got && st.wst == TCM_IDLE)
    begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
    end
    if (st.aw_got && st.w_got && st.wst == TCM_IDLE)
    begin
      wr_fire = 1'b1;
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.wst = TCM_RESP;
      next_st.bresp = `TCM_RESP_OK;
      // Byte lanes beyond the low half hold nothing; write strobes are ignored
      if (st.waddr == `TCM_ADDR_MODE)
      begin
        next_st.mode_reg = wd16 & `TCM_MODE_MASK;
        if (st.chan_en)
          next_st.mode_reg[`TCM_DIR_MSB:`TCM_DIR_LSB] =
            st.mode_reg[`TCM_DIR_MSB:`TCM_DIR_LSB];
      end
      else if (st.waddr == `TCM_ADDR_CTRL)
      begin
        next_st.counter_en = wd16[`TCM_CEN_BIT];
        next_st.one_pulse_mode = wd16[`TCM_ONE_PULSE_BIT];
      end
      else if (st.waddr == `TCM_ADDR_EVT)
        upd_gen_wr = wd16[`TCM_UPD_GEN_BIT];
      else if (st.waddr == `TCM_ADDR_CHEN)
      begin
        next_st.chan_en = wd16[`TCM_CHEN_BIT];
        next_st.output_polarity = wd16[`TCM_POL_BIT];
      end
      else if (st.waddr == `TCM_ADDR_CMP)
      begin
        next_st.cmp_preload = wd16;
        if (!pe)
          next_st.cmp_active = wd16;
      end
      else if (st.waddr == `TCM_ADDR_CNT)
        next_st.counter_value = wd16;
      else if (st.waddr == `TCM_ADDR_RELOAD)
        next_st.reload = wd16;
      else
        next_st.bresp = `TCM_RESP_ERR;
    end
    if (st.wst == TCM_RESP && s_axi_bready)
      next_st.wst = TCM_IDLE;

    // Read channel
    if (st.rst == TCM_IDLE && s_axi_arvalid)
    begin
      rd_fire = 1'b1;
      next_st.rst = TCM_RESP;
      next_st.rresp = `TCM_RESP_OK;
      next_st.rdata = '0;
      if (s_axi_araddr == `TCM_ADDR_MODE)
        next_st.rdata[15:0] = st.mode_reg;
      else if (s_axi_araddr == `TCM_ADDR_CTRL)
      begin
        next_st.rdata[`TCM_CEN_BIT] = st.counter_en;
        next_st.rdata[`TCM_ONE_PULSE_BIT] = st.one_pulse_mode;
      end
      else if (s_axi_araddr == `TCM_ADDR_EVT)
        next_st.rdata = '0;
      else if (s_axi_araddr == `TCM_ADDR_CHEN)
      begin
        next_st.rdata[`TCM_CHEN_BIT] = st.chan_en;
        next_st.rdata[`TCM_POL_BIT] = st.output_polarity;
      end
      else if (s_axi_araddr == `TCM_ADDR_CMP)
        next_st.rdata[15:0] = pe ? st.cmp_preload : st.cmp_active;
      else if (s_axi_araddr == `TCM_ADDR_CNT)
        next_st.rdata[15:0] = st.counter_value;
      else if (s_axi_araddr == `TCM_ADDR_RELOAD)
        next_st.rdata[15:0] = st.reload;
      else
        next_st.rresp = `TCM_RESP_ERR;
    end
    if (st.rst == TCM_RESP && s_axi_rready)
      next_st.rst = TCM_IDLE;

    // Up counter; overflow at the reload value
    overflow = st.counter_en && (st.counter_value == st.reload);
    upd_now = upd_gen_wr || overflow;
    if (upd_gen_wr)
      next_st.counter_value = `TCM_RST16;
    else if (overflow)
    begin
      next_st.counter_value = `TCM_RST16;
      // One-pulse stops the counter at the end of the period
      if (st.one_pulse_mode)
        next_st.counter_en = 1'b0;
    end
    else if (st.counter_en && !(wr_fire && st.waddr == `TCM_ADDR_CNT))
      next_st.counter_value = st.counter_value + 16'h0001;

    // Preload transfer; a same-cycle compare write still wins as newest value
    if (upd_now && pe)
      next_st.cmp_active = (wr_fire && st.waddr == `TCM_ADDR_CMP) ? wd16 : st.cmp_preload;
    next_st.upd = upd_now;

    // Pin forced low while the channel is off, whatever the polarity
    next_st.chan_out = st.chan_en &&
      (cmp_bus.output_reference ^ st.output_polarity);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.reload <= `TCM_RELOAD_RST;
    end
    else
      st <= next_st;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign s_axi_awready = st.wst == TCM_IDLE && !st.aw_got;
  assign s_axi_wready = st.wst == TCM_IDLE && !st.w_got;
  assign s_axi_bvalid = st.wst == TCM_RESP;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.rst == TCM_IDLE;
  assign s_axi_rvalid = st.rst == TCM_RESP;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign output_reference = cmp_bus.output_reference;
  assign channel_output = st.chan_out;
  assign update_event = st.upd;
endmodule

// [logic/tcm_map.svh]
`ifndef TCM_MAP_SVH
`define TCM_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define TCM_ADDR_MODE 8'h18
`define TCM_ADDR_CTRL 8'h00
`define TCM_ADDR_EVT 8'h14
`define TCM_ADDR_CHEN 8'h20
`define TCM_ADDR_CMP 8'h34
`define TCM_ADDR_CNT 8'h24
`define TCM_ADDR_RELOAD 8'h2C

// ----------------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------------
`define TCM_DIR_LSB 0
`define TCM_DIR_MSB 1
`define TCM_PE_BIT 3
`define TCM_OCM_LSB 4
`define TCM_OCM_MSB 6
`define TCM_CEN_BIT 0
`define TCM_ONE_PULSE_BIT 3
`define TCM_UPD_GEN_BIT 0
`define TCM_CHEN_BIT 0
`define TCM_POL_BIT 1
`define TCM_DIR_OUT 2'h0
`define TCM_OCM_FROZEN 3'h0
`define TCM_OCM_SET 3'h1
`define TCM_OCM_CLR 3'h2
`define TCM_OCM_TOG 3'h3
`define TCM_OCM_LOW 3'h4
`define TCM_OCM_HIGH 3'h5
`define TCM_OCM_PWM1 3'h6
`define TCM_OCM_PWM2 3'h7
`define TCM_RST16 16'h0000
`define TCM_RELOAD_RST 16'hFFFF
`define TCM_MODE_MASK 16'h007B
`define TCM_RESP_OK 2'h0
`define TCM_RESP_ERR 2'h2
`endif

// [logic/tcm_pkg.sv]
package tcm_pkg;
  typedef enum logic [1:0] {TCM_IDLE, TCM_RESP} tcm_bus_state_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [15:0] count;
    logic [15:0] cmp_active;
    logic below;
    logic was_frozen;
    logic ref_level;
  } tcm_cmp_state_t;
endpackage

// [logic/tcm_cmp_if.sv]
`timescale 1ns/1ps
interface tcm_cmp_if;
  logic [2:0] mode;
  logic output_dir;
  logic [15:0] counter_value;
  logic [15:0] compare_value;
  logic output_reference;
  modport ctrl (output mode, output output_dir, output counter_value, output compare_value,
    input output_reference);
  modport gen (input mode, input output_dir, input counter_value, input compare_value,
    output output_reference);
endinterface

// [logic/tcm_ref_gen.sv]
`timescale 1ns/1ps
`include "tcm_map.svh"
module tcm_ref_gen
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Compare stage
  tcm_cmp_if.gen cmp
);
  import tcm_pkg::*;

  tcm_cmp_state_t st;
  tcm_cmp_state_t next_st;
  logic below_now;
  logic match_now;
  logic pwm_lvl;

  always_comb
  begin
    next_st = st;
    below_now = cmp.counter_value < cmp.compare_value;
    match_now = cmp.counter_value == cmp.compare_value;
    pwm_lvl = (cmp.mode == `TCM_OCM_PWM1) ? below_now : !below_now;
    next_st.mode = cmp.mode;
    next_st.below = below_now;
    next_st.was_frozen = (cmp.mode == `TCM_OCM_FROZEN);
    if (cmp.output_dir)
    begin
      case (cmp.mode)
        `TCM_OCM_FROZEN: next_st.ref_level = st.ref_level;
        `TCM_OCM_SET: if (match_now) next_st.ref_level = 1'b1;
        `TCM_OCM_CLR: if (match_now) next_st.ref_level = 1'b0;
        `TCM_OCM_TOG: if (match_now) next_st.ref_level = !st.ref_level;
        `TCM_OCM_LOW: next_st.ref_level = 1'b0;
        `TCM_OCM_HIGH: next_st.ref_level = 1'b1;
        default:
        begin
          // Level moves only on a compare change, on a mode change or on leaving frozen
          if (below_now != st.below || st.was_frozen || st.mode != cmp.mode)
            next_st.ref_level = pwm_lvl;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.was_frozen <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign cmp.output_reference = st.ref_level;
endmodule

// [verif/tcm_chk.sv]
`timescale 1ns/1ps
module tcm_chk
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel pins
  input wire logic output_reference,
  input wire logic update_event
);
  // --------------------------------------------------------------
  // Bus timing and pin quiet states
  // --------------------------------------------------------------
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  chk_wr_latency: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_wr_done: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write answer not closed");
  chk_rd_done: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not closed");
  chk_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  chk_wr_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !rst_n |=> !s_axi_bvalid && !s_axi_rvalid && !output_reference && !update_event)
    else $error("pins not quiet in reset");
  chk_update_pulse: assert property ($rose(update_event) |=> !update_event)
    else $error("update pulse too wide");
endmodule

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
  logic clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic output_reference, channel_output, update_event, ref_q;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] seq [10] = '{4, 1, 5, 2, 0, 6, 7, 5, 0, 6};
  int checks, fail_count, ups, tog, c, p, m, e, k, seed;

  tcm_top dut (.*);

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    ups <= ups + (update_event === 1'b1);
    tog <= tog + (output_reference !== ref_q);
    ref_q <= output_reference;
  end

  // --------------------------------------------------------------
  // Checking, bus and model helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x)
    begin
      fail_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task conclude;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Readiness is sampled at the falling edge so the handshake never races the design
  task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] er = 2'h0);
    logic [2:0] t;
    logic [1:0] r;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    t = 3'h0;
    // The wait for the answer ends once s_axi_bvalid is seen at a falling edge
    while (!t[0])
    begin
      @(negedge clk_sys);
      t = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid};
      r = s_axi_bresp;
      @(posedge clk_sys);
      if (t[2]) s_axi_awvalid <= 1'b0;
      if (t[1]) s_axi_wvalid <= 1'b0;
      if (t[0]) s_axi_bready <= 1'b0;
    end
    chk(r, er);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = 2'h0);
    logic [1:0] t;
    logic [1:0] r;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    t = 2'h0;
    while (!t[0])
    begin
      @(negedge clk_sys);
      t = {s_axi_arvalid & s_axi_arready, s_axi_rvalid};
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      if (t[1]) s_axi_arvalid <= 1'b0;
      if (t[0]) s_axi_rready <= 1'b0;
    end
    chk(r, er);
  endtask

  task automatic cref(input logic x);
    repeat (4) @(negedge clk_sys);
    chk(output_reference, x);
  endtask

  function automatic int model(int md, int cv, int pv, int prev);
    case (md)
      1: return (cv == pv) ? 1 : prev;
      2: return (cv == pv) ? 0 : prev;
      4: return 0;
      5: return 1;
      6: return cv < pv;
      7: return cv >= pv;
      default: return prev;
    endcase
  endfunction

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    seed = 32'h7576;
    rst_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h18, d);
    chk(d, 32'h00000000);
    wr(8'h18, 16'hFFFF);
    rd(8'h18, d);
    chk(d, 32'h0000007B);
    wr(8'h40, 16'h0001, 2'h2);
    rd(8'h40, d, 2'h2);
    $display("test registers done");
    // Input direction: a forced-high mode must not reach the reference
    wr(8'h18, 16'h0051);
    cref(1'b0);
    wr(8'h18, 16'h0050);
    wr(8'h20, 16'h0001);
    wr(8'h18, 16'h0051);
    rd(8'h18, d);
    chk(d, 32'h00000050);
    for (k = 0; k < 2; k++)
    begin
      wr(8'h20, {14'h0000, k[0], 1'b1});
      cref(1'b1);
      chk(channel_output, !k[0]);
    end
    $display("test direction and polarity done");
    // One-pulse set with the counter off, so PWM without preload stays legal
    wr(8'h00, 16'h0008);
    wr(8'h24, 16'h0005);
    wr(8'h34, 16'h0005);
    e = 0;
    foreach (seq[i])
    begin
      wr(8'h18, {9'h000, seq[i], 4'h0});
      e = model(seq[i], 5, 5, e);
      cref(e[0]);
    end
    for (k = 0; k < 6; k++)
    begin
      c = $random(seed) & 32'h0000FFFF;
      p = $random(seed) & 32'h0000FFFF;
      wr(8'h24, c[15:0]);
      wr(8'h34, p[15:0]);
      m = 6 + k % 2;
      wr(8'h18, {9'h000, m[2:0], 4'h0});
      e = model(m, c, p, e);
      cref(e[0]);
    end
    $display("test modes done");
    wr(8'h34, 16'h0008);
    wr(8'h24, 16'h0005);
    wr(8'h18, 16'h0068);
    cref(1'b1);
    wr(8'h34, 16'h0000);
    cref(1'b1);
    rd(8'h34, d);
    chk(d, 32'h00000000);
    k = ups;
    wr(8'h14, 16'h0001);
    cref(1'b0);
    chk(ups - k, 1);
    $display("test preload done");
    // Preload off before the compare write, else the value would wait for an update
    wr(8'h18, 16'h0030);
    wr(8'h34, 16'h0003);
    wr(8'h2C, 16'h0007);
    wr(8'h00, 16'h0001);
    repeat (16) @(posedge clk_sys);
    k = ups;
    m = tog;
    repeat (32) @(posedge clk_sys);
    chk(ups - k, 4);
    chk(tog - m, 4);
    $display("test running counter done");
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    conclude();
  end
endmodule

bind tcm_top tcm_chk chk_i (.*);
